// [hdl/twm_top.sv]
`timescale 1ns/1ns
module twm_top #(
  parameter int CH_IDX = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [3:0] presc_tick,
  input wire logic timer_input_pin,
  output logic channel_timer_interrupt,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [twm_pkg::TWM_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [twm_pkg::TWM_AW-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  import twm_pkg::*;

  localparam bit HAS_UPPER = (CH_IDX == 1) || (CH_IDX == 3);
  localparam bit HAS_CHBIT = HAS_UPPER || (CH_IDX == 2) || (CH_IDX == 4) || (CH_IDX == 6);

  function automatic logic addr_ok(input logic [TWM_AW-1:0] a);
    addr_ok = (a == TWM_OFS_TRIG) || (a == TWM_OFS_ENST) || (a == TWM_OFS_MODE) ||
              (a == TWM_OFS_DATA) || (a == TWM_OFS_CNT) || (a == TWM_OFS_STAT) ||
              (a == TWM_OFS_PWR);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge = (old & ~m) | (nw & m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus slave
  logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [TWM_AW-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_do, rd_do;
  logic [31:0] rd_mux;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign wr_do = ce && aw_have_q && w_have_q && !bvalid_q;
  assign rd_do = ce && s_axi_arvalid && !rvalid_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bresp_q <= TWM_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= addr_ok(awaddr_q) ? TWM_RESP_OKAY : TWM_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= TWM_RESP_OKAY;
    end else if (ce) begin
      if (rd_do) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= addr_ok(s_axi_araddr) ? TWM_RESP_OKAY : TWM_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic pwr_q, act;
  logic [31:0] mode_q, mode_wr, data_wr;
  logic [TWM_CW-1:0] data_q, count_q;
  logic ovf_q, ovf_seen_q, up_en_q, irq_q;
  twm_state_e state_q;
  logic wr_trig, start_p, stop_p, up_start_p, up_stop_p;
  logic [3:0] md;
  logic [1:0] edge_sel, cks;
  logic is_width, is_delay, op_tick, pin_rise, pin_fall;
  logic start_edge, cap_edge, en_st;

  assign act = ce && pwr_q;
  assign wr_trig = wr_do && pwr_q && (awaddr_q == TWM_OFS_TRIG);
  assign start_p = wr_trig && wstrb_q[0] && wdata_q[TWM_B_START];
  assign stop_p = wr_trig && wstrb_q[0] && wdata_q[TWM_B_STOP];
  assign up_start_p = HAS_UPPER && wr_trig && wstrb_q[1] && wdata_q[TWM_B_UPSTART];
  assign up_stop_p = HAS_UPPER && wr_trig && wstrb_q[1] && wdata_q[TWM_B_UPSTOP];

  // power bit sits outside the channel reset so software can turn it back on
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pwr_q <= 1'b0;
    end else if (wr_do && awaddr_q == TWM_OFS_PWR && wstrb_q[0]) begin
      pwr_q <= wdata_q[TWM_B_PWR];
    end
  end

  assign mode_wr = merge(mode_q, wdata_q, wstrb_q) & TWM_MODE_MASK;
  assign data_wr = merge({16'h0000, data_q}, wdata_q, wstrb_q);

  // unsupported select bits are forced low per channel
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_q <= TWM_MODE_RST;
    end else if (ce) begin
      if (!pwr_q) begin
        mode_q <= TWM_MODE_RST;
      end else if (wr_do && awaddr_q == TWM_OFS_MODE) begin
        mode_q <= mode_wr;
        mode_q[TWM_M_CHBIT] <= HAS_CHBIT && mode_wr[TWM_M_CHBIT];
        mode_q[TWM_M_CKS_LO] <= HAS_UPPER && mode_wr[TWM_M_CKS_LO];
      end
    end
  end

  assign md = mode_q[TWM_M_MD_LO +: 4];
  assign edge_sel = mode_q[TWM_M_EDGE_LO +: 2];
  assign cks = mode_q[TWM_M_CKS_LO +: 2];
  assign is_width = (md == TWM_MD_WIDTH);
  assign is_delay = (md == TWM_MD_DELAY);
  assign en_st = (state_q != TWM_ST_OFF);

  always_comb begin
    case (cks)
      TWM_CKS_0: op_tick = presc_tick[0];
      TWM_CKS_1: op_tick = presc_tick[1];
      TWM_CKS_2: op_tick = presc_tick[2];
      TWM_CKS_3: op_tick = presc_tick[3];
      default: op_tick = presc_tick[0];
    endcase
  end

  twm_edge u_edge (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .pin(timer_input_pin),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // width: low measures fall..rise, high measures rise..fall
  always_comb begin
    start_edge = 1'b0;
    cap_edge = 1'b0;
    case (edge_sel)
      TWM_EDGE_FALL: start_edge = pin_fall;
      TWM_EDGE_RISE: start_edge = pin_rise;
      TWM_EDGE_LOW: begin
        start_edge = pin_fall;
        cap_edge = pin_rise;
      end
      TWM_EDGE_HIGH: begin
        start_edge = is_width ? pin_rise : (pin_rise | pin_fall);
        cap_edge = pin_fall;
      end
      default: start_edge = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel engine
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= TWM_ST_OFF;
      count_q <= TWM_CNT_ZERO;
      ovf_seen_q <= 1'b0;
      ovf_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= 1'b0;
      if (!pwr_q) begin
        state_q <= TWM_ST_OFF;
        count_q <= TWM_CNT_ZERO;
        ovf_seen_q <= 1'b0;
        ovf_q <= 1'b0;
      end else if (stop_p) begin
        state_q <= TWM_ST_OFF;
      end else if (is_width) begin
        case (state_q)
          TWM_ST_OFF: if (start_p) state_q <= TWM_ST_WAIT;
          TWM_ST_WAIT: begin
            if (start_edge) begin
              count_q <= TWM_CNT_ZERO;
              ovf_seen_q <= 1'b0;
              state_q <= TWM_ST_RUN;
            end
          end
          TWM_ST_RUN: begin
            if (cap_edge) begin
              ovf_q <= ovf_seen_q;
              irq_q <= 1'b1;
              state_q <= TWM_ST_WAIT;
            end else if (op_tick) begin
              count_q <= count_q + TWM_CNT_ONE;
              if (count_q == TWM_CNT_MAX) ovf_seen_q <= 1'b1;
            end
          end
          default: state_q <= TWM_ST_WAIT;
        endcase
      end else if (is_delay) begin
        case (state_q)
          TWM_ST_OFF: if (start_p) state_q <= TWM_ST_WAIT;
          TWM_ST_WAIT, TWM_ST_RUN: begin
            if (start_p || start_edge) begin
              state_q <= TWM_ST_LOAD;
            end else if (state_q == TWM_ST_RUN && op_tick) begin
              count_q <= count_q - TWM_CNT_ONE;
              if (count_q == TWM_CNT_ONE) begin
                irq_q <= 1'b1;
                state_q <= TWM_ST_WAIT;
              end
            end
          end
          TWM_ST_LOAD: begin
            if (op_tick) begin
              count_q <= data_q;
              if (data_q == TWM_CNT_ZERO) begin
                irq_q <= 1'b1;
                state_q <= TWM_ST_WAIT;
              end else begin
                state_q <= TWM_ST_RUN;
              end
            end
          end
          default: state_q <= TWM_ST_WAIT;
        endcase
      end else if (start_p) begin
        state_q <= TWM_ST_WAIT;
      end
    end
  end

  // capture wins over a software write landing in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      data_q <= TWM_DATA_RST;
    end else if (ce) begin
      if (!pwr_q) begin
        data_q <= TWM_DATA_RST;
      end else if (is_width && state_q == TWM_ST_RUN && cap_edge && !stop_p) begin
        data_q <= count_q;
      end else if (wr_do && awaddr_q == TWM_OFS_DATA) begin
        data_q <= data_wr[TWM_CW-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      up_en_q <= 1'b0;
    end else if (ce) begin
      if (!pwr_q || up_stop_p) begin
        up_en_q <= 1'b0;
      end else if (up_start_p) begin
        up_en_q <= 1'b1;
      end
    end
  end

  assign channel_timer_interrupt = irq_q;

  // trigger register has no storage, so it reads zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      TWM_OFS_TRIG: rd_mux = 32'h0000_0000;
      TWM_OFS_ENST: begin
        rd_mux[TWM_B_EN] = en_st;
        rd_mux[TWM_B_UPEN] = up_en_q;
      end
      TWM_OFS_MODE: rd_mux = mode_q;
      TWM_OFS_DATA: rd_mux[TWM_CW-1:0] = data_q;
      TWM_OFS_CNT: rd_mux[TWM_CW-1:0] = count_q;
      TWM_OFS_STAT: rd_mux[TWM_B_OVF] = ovf_q;
      TWM_OFS_PWR: rd_mux[TWM_B_PWR] = pwr_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_capture;
    act && is_width && state_q == TWM_ST_RUN && cap_edge && !stop_p;
  endsequence

  sequence s_zero_reach;
    act && is_delay && state_q == TWM_ST_RUN && op_tick && count_q == TWM_CNT_ONE &&
      !stop_p && !start_p && !start_edge;
  endsequence

  start_sets_en_a: assert property (
    (act && is_width && state_q == TWM_ST_OFF && start_p && !stop_p)
      |=> (state_q == TWM_ST_WAIT && en_st))
    else $error("start trigger did not enter wait state");

  trig_reads_zero_a: assert property (
    (rd_do && s_axi_araddr == TWM_OFS_TRIG) |=> (s_axi_rvalid && s_axi_rdata == 32'h0000_0000))
    else $error("trigger register read back nonzero");

  start_clears_cnt_a: assert property (
    (act && is_width && state_q == TWM_ST_WAIT && start_edge && !stop_p)
      |=> (count_q == TWM_CNT_ZERO && state_q == TWM_ST_RUN))
    else $error("start edge did not clear count");

  capture_copies_a: assert property (
    s_capture |=> (data_q == $past(count_q) && channel_timer_interrupt))
    else $error("capture did not copy count or raise interrupt");

  ovf_capture_a: assert property (
    s_capture |=> (ovf_q == $past(ovf_seen_q)))
    else $error("overflow flag not updated at capture");

  halt_after_cap_a: assert property (
    s_capture |=> (state_q == TWM_ST_WAIT) ##1
      ($stable(count_q) || $past(start_edge) || $past(!pwr_q)))
    else $error("counter kept running after capture");

  stop_holds_a: assert property (
    (act && stop_p) |=> (!en_st && $stable(count_q) && $stable(ovf_q)))
    else $error("stop did not halt with values held");

  pwr_off_a: assert property (
    (ce && !pwr_q) |=> (state_q == TWM_ST_OFF && count_q == TWM_CNT_ZERO &&
                        data_q == TWM_DATA_RST && !ovf_q))
    else $error("power off did not reset channel");

  delay_zero_irq_a: assert property (
    s_zero_reach |=> (channel_timer_interrupt && count_q == TWM_CNT_ZERO &&
                      state_q == TWM_ST_WAIT))
    else $error("zero reach without interrupt and halt");

  delay_load_a: assert property (
    (act && is_delay && state_q == TWM_ST_LOAD && op_tick && !stop_p && !start_p &&
     !start_edge) |=> (count_q == $past(data_q)))
    else $error("delay start did not load data value");
endmodule

// [shared/twm_pkg.sv]
// Function
// - width mode start trigger sets enable status and waits for the start edge
// - start trigger bit is self-clearing and always reads back zero
// - start edge clears the count to zero and counting up begins
// - capture edge copies count into data register and raises the interrupt
// - each capture sets overflow if the counter wrapped, otherwise clears it
// - after capture the counter halts and waits for the next start edge
// - data, count and status registers read anytime without side effects
// - stop trigger clears enable and halts counting, keeping count and overflow
// - overflow bit keeps its value from the moment of the stop trigger
// - clearing unit power enable resets all channel logic and registers
// - delay mode start trigger while enabled also starts a down-count
// - delay from trigger to interrupt is count period times data plus one
// - start bits, upper ones on channels 1 and 3, set matching enable bits
// - on delay start the counter loads the data value then decrements
// - down-count reaching zero raises the interrupt and stops until retriggered
// - data writes allowed anytime, taking effect only from the next period
// - clock select 00 and 10 pick clocks 0 and 1; 01, 11 only channels 1, 3
// - channel bit is master on 2, 4, 6, split on 1, 3, zero elsewhere
// - edge select 10 measures low width, 11 measures high width
package twm_pkg;
  localparam int TWM_AW = 8;
  localparam int TWM_CW = 16;
  localparam logic [TWM_AW-1:0] TWM_OFS_TRIG = 8'h00;
  localparam logic [TWM_AW-1:0] TWM_OFS_ENST = 8'h04;
  localparam logic [TWM_AW-1:0] TWM_OFS_MODE = 8'h08;
  localparam logic [TWM_AW-1:0] TWM_OFS_DATA = 8'h0c;
  localparam logic [TWM_AW-1:0] TWM_OFS_CNT = 8'h10;
  localparam logic [TWM_AW-1:0] TWM_OFS_STAT = 8'h14;
  localparam logic [TWM_AW-1:0] TWM_OFS_PWR = 8'h18;
  localparam int TWM_B_START = 0;
  localparam int TWM_B_STOP = 1;
  localparam int TWM_B_UPSTART = 8;
  localparam int TWM_B_UPSTOP = 9;
  localparam int TWM_B_EN = 0;
  localparam int TWM_B_UPEN = 8;
  localparam int TWM_B_OVF = 0;
  localparam int TWM_B_PWR = 0;
  localparam int TWM_M_MD_LO = 0;
  localparam int TWM_M_EDGE_LO = 6;
  localparam int TWM_M_CHBIT = 11;
  localparam int TWM_M_CKS_LO = 14;
  localparam logic [31:0] TWM_MODE_MASK = 32'h0000_c8cf;
  localparam logic [31:0] TWM_MODE_RST = 32'h0000_0000;
  localparam logic [TWM_CW-1:0] TWM_DATA_RST = 16'h0000;
  localparam logic [TWM_CW-1:0] TWM_CNT_ZERO = 16'h0000;
  localparam logic [TWM_CW-1:0] TWM_CNT_ONE = 16'h0001;
  localparam logic [TWM_CW-1:0] TWM_CNT_MAX = 16'hffff;
  localparam logic [3:0] TWM_MD_WIDTH = 4'hc;
  localparam logic [3:0] TWM_MD_DELAY = 4'h8;
  localparam logic [1:0] TWM_EDGE_FALL = 2'h0;
  localparam logic [1:0] TWM_EDGE_RISE = 2'h1;
  localparam logic [1:0] TWM_EDGE_LOW = 2'h2;
  localparam logic [1:0] TWM_EDGE_HIGH = 2'h3;
  localparam logic [1:0] TWM_CKS_0 = 2'h0;
  localparam logic [1:0] TWM_CKS_1 = 2'h2;
  localparam logic [1:0] TWM_CKS_2 = 2'h1;
  localparam logic [1:0] TWM_CKS_3 = 2'h3;
  localparam logic [1:0] TWM_RESP_OKAY = 2'h0;
  localparam logic [1:0] TWM_RESP_SLVERR = 2'h2;
  localparam int TWM_SYNC_STAGES = 2;
  typedef enum logic [1:0] {TWM_ST_OFF, TWM_ST_WAIT, TWM_ST_LOAD, TWM_ST_RUN} twm_state_e;
endpackage

// [hdl/twm_edge.sv]
`timescale 1ns/1ns
module twm_edge (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic pin,
  output logic rise,
  output logic fall
);
  import twm_pkg::*;
  logic [TWM_SYNC_STAGES-1:0] sync_q;
  logic hist_q;

  // first stage feeds only the next stage
  genvar i;
  generate
    for (i = 0; i < TWM_SYNC_STAGES; i++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          sync_q[i] <= 1'b0;
        end else if (ce) begin
          sync_q[i] <= (i == 0) ? pin : sync_q[(i == 0) ? 0 : i - 1];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hist_q <= 1'b0;
    end else if (ce) begin
      hist_q <= sync_q[TWM_SYNC_STAGES-1];
    end
  end

  assign rise = sync_q[TWM_SYNC_STAGES-1] & ~hist_q;
  assign fall = ~sync_q[TWM_SYNC_STAGES-1] & hist_q;
endmodule

// [sim/twm_pin_model.sv]
`timescale 1ns/1ns
module twm_pin_model (
  input wire logic clk,
  output logic pin
);
  // no pull on this pin: it shows only what is driven
  initial pin = 1'b0;
  task automatic set_lvl(input logic lvl);
    pin <= lvl;
  endtask
  task automatic pulse(input logic lvl, input int cyc);
    pin <= lvl;
    repeat (cyc) @(posedge clk);
    pin <= ~lvl;
  endtask
endmodule

// [sim/timer_width_measure_delay_count_tb.sv]
`timescale 1ns/1ns
module timer_width_measure_delay_count_tb;
  import twm_pkg::*;
  logic clk, rst_b, irq, pin, tick_en;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0] tick, wstrb;
  logic ce = 1'b1;
  bit ce_rnd = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp, resp;
  int n_fail = 0, num_checks = 0, ph = 0, tcount = 0, n_irq = 0, tsel = 0, k, d, n0;
  int per[4] = '{8, 8, 8, 8};
  logic [1:0] cks_c[4] = '{TWM_CKS_0, TWM_CKS_1, TWM_CKS_2, TWM_CKS_3};
  logic [7:0] ofs[7] = '{TWM_OFS_MODE, TWM_OFS_DATA, TWM_OFS_CNT, TWM_OFS_STAT,
    TWM_OFS_ENST, TWM_OFS_PWR, TWM_OFS_TRIG};
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  twm_top #(.CH_IDX(1)) i_dut (
    .clk(clk), .rst_b(rst_b), .ce(ce), .presc_tick(tick), .timer_input_pin(pin),
    .channel_timer_interrupt(irq), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp)
  );
  twm_pin_model i_pin (.clk(clk), .pin(pin));
  ////////////////////////////////////////////////////////////////////////////////
  // count-clock enables; gated so a trigger never lands on a tick edge
  always @(posedge clk) begin
    ph <= tick_en ? ph + 1 : 0;
    for (int i = 0; i < 4; i++)
      tick[i] <= tick_en && (ph % per[i] == 0);
  end
  // random freezes while ce_rnd is set; the design must lose nothing but time
  always @(posedge clk) ce <= !ce_rnd || ($urandom_range(3) != 0);
  // only ticks the counter can take: ce high and no interrupt pending
  always @(negedge clk) begin
    if (tick[tsel] === 1'b1 && ce === 1'b1 && irq !== 1'b1) tcount++;
    if (irq === 1'b1 && ce === 1'b1) n_irq++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] mode_w(logic [3:0] md, logic [1:0] e, logic [1:0] c);
    mode_w = 32'(md) | (32'(e) << TWM_M_EDGE_LO) | (32'h1 << TWM_M_CHBIT) |
      (32'(c) << TWM_M_CKS_LO);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // the slave moves an item only at an edge where ce is high; one idle edge between calls
  task automatic wr_be(input logic [7:0] a, input logic [31:0] dt, input logic [3:0] be);
    bit hb;
    hb = 1'b0;
    awaddr <= a;
    wdata <= dt;
    wstrb <= be;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!hb) begin
      @(posedge clk);
      if (ce && awvalid && awready) awvalid <= 1'b0;
      if (ce && wvalid && wready) wvalid <= 1'b0;
      if (ce && bvalid && bready) begin
        hb = 1'b1;
        resp = bresp;
        bready <= 1'b0;
      end
    end
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    wr_be(a, dt, 4'hf);
  endtask
  task automatic rd(input logic [7:0] a);
    bit hr;
    hr = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hr) begin
      @(posedge clk);
      if (ce && arvalid && arready) arvalid <= 1'b0;
      if (ce && rvalid && rready) begin
        hr = 1'b1;
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
      end
    end
    @(posedge clk);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, v, e);
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 3000 && n_irq == n0; i++) @(posedge clk);
    chk("irq", n_irq, n0 + 1);
  endtask
  // pin edges placed mid-period so the tick count is exact
  task automatic align();
    for (int i = 0; i < 16 && ph % 8 != 3; i++) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(95000 * 50);
    n_fail++;
    test_done();
  end
  initial begin
    rst_b = 1'b0;
    tick_en = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    tick = '0;
    void'($urandom(66435));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 7; i++) rc("reset", ofs[i], 32'h0);
    wr(TWM_OFS_PWR, 32'h1);
    chk("bresp", resp, TWM_RESP_OKAY);
    wr(TWM_OFS_DATA, 32'h1234);
    wr_be(TWM_OFS_DATA, 32'h56ab, 4'h1);
    rc("strobe", TWM_OFS_DATA, 32'h12ab);
    chk("rresp", resp, TWM_RESP_OKAY);
    wr_be(TWM_OFS_TRIG, 32'h1 << TWM_B_UPSTART, 4'h2);
    rc("upper enable", TWM_OFS_ENST, 32'h1 << TWM_B_UPEN);
    wr_be(TWM_OFS_TRIG, 32'h1 << TWM_B_UPSTOP, 4'h2);
    rc("upper stop", TWM_OFS_ENST, 32'h0);
    wr(8'h40, 32'h1234);
    chk("bresp unmapped", resp, TWM_RESP_SLVERR);
    rc("unmapped", 8'h40, 32'h0);
    chk("rresp unmapped", resp, TWM_RESP_SLVERR);
    // delay mode, every clock select code, software start, random freezes
    ce_rnd <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      tsel = s;
      per[s] = 5 + $urandom_range(7);
      d = (s == 0) ? 0 : $urandom_range(15);
      wr(TWM_OFS_MODE, mode_w(TWM_MD_DELAY, TWM_EDGE_RISE, cks_c[s]));
      rc("mode", TWM_OFS_MODE, mode_w(TWM_MD_DELAY, TWM_EDGE_RISE, cks_c[s]));
      wr(TWM_OFS_DATA, 32'(d));
      tick_en <= 1'b0;
      wr(TWM_OFS_TRIG, 32'h1);
      rc("enable", TWM_OFS_ENST, 32'h1);
      rc("trig", TWM_OFS_TRIG, 32'h0);
      n0 = n_irq;
      wr(TWM_OFS_TRIG, 32'h1);
      tcount = 0;
      tick_en <= 1'b1;
      wait_irq();
      chk("ticks", tcount, d + 1);
      n0 = n_irq;
      repeat (3 * per[s]) @(posedge clk);
      chk("stopped", n_irq, n0);
      rc("count", TWM_OFS_CNT, 32'h0);
      wr(TWM_OFS_TRIG, 32'h2);
    end
    ce_rnd <= 1'b0;
    // pin-started delay, data rewritten mid-count
    tsel = 1;
    d = 3 + $urandom_range(8);
    k = $urandom_range(20);
    wr(TWM_OFS_MODE, mode_w(TWM_MD_DELAY, TWM_EDGE_RISE, cks_c[1]));
    wr(TWM_OFS_DATA, 32'(d));
    wr(TWM_OFS_TRIG, 32'h1);
    tick_en <= 1'b0;
    i_pin.set_lvl(1'b1);
    repeat (6) @(posedge clk);
    n0 = n_irq;
    tcount = 0;
    tick_en <= 1'b1;
    for (int i = 0; i < 100 && tcount < 2; i++) @(posedge clk);
    tick_en <= 1'b0;
    wr(TWM_OFS_DATA, 32'(k));
    tick_en <= 1'b1;
    wait_irq();
    chk("old data", tcount, d + 1);
    n0 = n_irq;
    tick_en <= 1'b0;
    wr(TWM_OFS_TRIG, 32'h1);
    tcount = 0;
    tick_en <= 1'b1;
    wait_irq();
    chk("new data", tcount, k + 1);
    wr(TWM_OFS_TRIG, 32'h2);
    i_pin.set_lvl(1'b0);
    // width mode: long pulse wraps the counter
    tsel = 0;
    per[0] = 1;
    wr(TWM_OFS_MODE, mode_w(TWM_MD_WIDTH, TWM_EDGE_HIGH, TWM_CKS_0));
    wr(TWM_OFS_TRIG, 32'h1);
    rc("enable", TWM_OFS_ENST, 32'h1);
    n0 = n_irq;
    i_pin.pulse(1'b1, 65540);
    repeat (8) @(posedge clk);
    chk("irq", n_irq, n0 + 1);
    rc("ovf", TWM_OFS_STAT, 32'h1);
    // stop in mid-pulse: count and flag frozen, no capture
    per[0] = 8;
    n0 = n_irq;
    align();
    i_pin.set_lvl(1'b1);
    repeat (40) @(posedge clk);
    rd(TWM_OFS_CNT);
    k = v;
    repeat (16) @(posedge clk);
    rd(TWM_OFS_CNT);
    chk("counting", 32'(v > k), 32'h1);
    wr(TWM_OFS_TRIG, 32'h2);
    rc("enable", TWM_OFS_ENST, 32'h0);
    rd(TWM_OFS_CNT);
    k = v;
    repeat (24) @(posedge clk);
    rc("held", TWM_OFS_CNT, 32'(k));
    rc("ovf held", TWM_OFS_STAT, 32'h1);
    i_pin.set_lvl(1'b0);
    repeat (8) @(posedge clk);
    chk("no capture", n_irq, n0);
    // high then low width, repeated pulses
    for (int e = 0; e < 2; e++) begin
      wr(TWM_OFS_TRIG, 32'h2);
      wr(TWM_OFS_MODE,
         mode_w(TWM_MD_WIDTH, e ? TWM_EDGE_LOW : TWM_EDGE_HIGH, TWM_CKS_0));
      i_pin.set_lvl(e == 1);
      repeat (8) @(posedge clk);
      wr(TWM_OFS_TRIG, 32'h1);
      for (int j = 0; j < 3; j++) begin
        k = 1 + $urandom_range(19);
        n0 = n_irq;
        align();
        i_pin.pulse(e == 0, 8 * k);
        repeat (16) @(posedge clk);
        chk("irq", n_irq, n0 + 1);
        rc("width", TWM_OFS_DATA, 32'(k));
        rc("ovf clear", TWM_OFS_STAT, 32'h0);
      end
    end
    // power off wipes everything and blocks writes
    wr(TWM_OFS_PWR, 32'h0);
    wr(TWM_OFS_MODE, mode_w(TWM_MD_DELAY, TWM_EDGE_RISE, TWM_CKS_1));
    for (int i = 0; i < 7; i++) rc("power off", ofs[i], 32'h0);
    test_done();
  end
endmodule
